/* verilog/ddcp_cfg.svh */
/*
 Frame layout, command and address codes, and power-on values of the serial
 command port. Definitions only; included by name from the design files.
*/
`ifndef DDCP_CFG_SVH
`define DDCP_CFG_SVH

`define DDCP_FRAME_BITS 24
`define DDCP_LAST_BIT   5'h17
`define DDCP_CMD_HI     21
`define DDCP_CMD_LO     19
`define DDCP_ADDR_HI    18
`define DDCP_ADDR_LO    16
`define DDCP_DATA_HI    15

`define DDCP_CMD_WR     3'h0
`define DDCP_CMD_UPD    3'h1
`define DDCP_CMD_WR_ALL 3'h2
`define DDCP_CMD_WR_UPD 3'h3
`define DDCP_CMD_PWR    3'h4
`define DDCP_CMD_SWRST  3'h5
`define DDCP_CMD_MASK   3'h6
`define DDCP_CMD_REF    3'h7

`define DDCP_ADDR_A     3'h0
`define DDCP_ADDR_B     3'h1
`define DDCP_ADDR_GAIN  3'h2
`define DDCP_ADDR_BOTH  3'h7

`define DDCP_PD_HI      5
`define DDCP_PD_LO      4

`define DDCP_ZERO_CODE  16'h0000
`define DDCP_MID_CODE   16'h8000
`define DDCP_GAIN_RST   2'h3
`define DDCP_PD_RST     2'h0
`define DDCP_MASK_RST   2'h0
`define DDCP_REF_RST    1'h0

`endif

/* verilog/ddcp_pkg.sv */
/*
 Types of the serial command port.
 Assumes the constants header is included where the numbers are needed.
*/
`default_nettype none
`include "ddcp_cfg.svh"

package ddcp_pkg;

	typedef enum logic [1:0] {
		RX_IDLE,
		RX_SHIFT,
		RX_PUSH,
		RX_LOCK
	} ddcp_rx_state_t;

	typedef logic [`DDCP_FRAME_BITS-1:0] ddcp_frame_t;

endpackage : ddcp_pkg

`default_nettype wire

/* verilog/ddcp_fifo.sv */
/*
 Flip-flop FIFO with valid/ready on both sides.
 Assumes one clock domain and a power-of-two depth.
*/
`timescale 1ns/10ps
`default_nettype none

module ddcp_fifo #(
	parameter int WIDTH = 24,
	parameter int DEPTH = 16
) (
	input  wire logic             clk,
	input  wire logic             rst,
	input  wire logic             wr_valid,
	output logic                  wr_ready,
	input  wire logic [WIDTH-1:0] wr_data,
	output logic                  rd_valid,
	input  wire logic             rd_ready,
	output logic [WIDTH-1:0]      rd_data
);
	localparam int PW = $clog2(DEPTH);

	if (DEPTH < 2 || (1 << PW) != DEPTH) begin : g_bad_depth
		$error("ddcp_fifo: DEPTH must be a power of two, at least 2");
	end

	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [PW:0]      wptr_r;
	logic [PW:0]      rptr_r;
	logic             push;
	logic             pop;

	assign wr_ready = (wptr_r ^ rptr_r) != {1'b1, {PW{1'b0}}};
	assign rd_valid = wptr_r != rptr_r;
	assign push     = wr_valid && wr_ready;
	assign pop      = rd_valid && rd_ready;
	assign rd_data  = mem_r[rptr_r[PW-1:0]];

	always_ff @(posedge clk) begin
		if (push) begin
			mem_r[wptr_r[PW-1:0]] <= wr_data;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wptr_r <= '0;
			rptr_r <= '0;
		end else begin
			if (push) begin
				wptr_r <= wptr_r + 1'b1;
			end
			if (pop) begin
				rptr_r <= rptr_r + 1'b1;
			end
		end
	end

endmodule : ddcp_fifo

`default_nettype wire

/* verilog/ddcp_top.sv */
/*
 Serial write port and command decoder of a dual-channel converter.
 Assumes frame select, serial clock, data, clear and load arrive
 asynchronously and are sampled by core_clk far faster than the link.
*/
`timescale 1ns/10ps
`default_nettype none
`include "ddcp_cfg.svh"

module ddcp_top #(
	parameter int RES_BITS   = 16,
	parameter bit MID_SCALE  = 1'b0,
	parameter int FIFO_DEPTH = 16
) (
	input  wire logic        core_clk,
	input  wire logic        sys_rst,
	input  wire logic        frame_sel_n,
	input  wire logic        serial_clk,
	input  wire logic        serial_data,
	input  wire logic        async_clear_in_n,
	input  wire logic        load_outputs_strobe_n,
	output logic [15:0]      dac_a_code,
	output logic [15:0]      dac_b_code,
	output logic [1:0]       gain_one,
	output logic [1:0]       pd_mode_a,
	output logic [1:0]       pd_mode_b,
	output logic [1:0]       load_inactive,
	output logic             ref_enable,
	output logic             clear_mode
);
	if (RES_BITS != 16 && RES_BITS != 14 && RES_BITS != 12) begin : g_bad_res
		$error("ddcp_top: RES_BITS must be 16, 14 or 12");
	end

	localparam logic [15:0] CODE_MASK = 16'(16'hFFFF << (16 - RES_BITS));
	localparam logic [15:0] RST_CODE  = MID_SCALE ? `DDCP_MID_CODE : `DDCP_ZERO_CODE;

	// pin synchronisers: bit 0 select, 1 clock, 2 data, 3 clear, 4 load
	logic [4:0] sync1_r;
	logic [4:0] sync2_r;
	logic [4:0] sync3_r;

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			sync1_r <= 5'h1F;
			sync2_r <= 5'h1F;
			sync3_r <= 5'h1F;
		end else begin
			sync1_r <= {load_outputs_strobe_n, async_clear_in_n, serial_data,
			            serial_clk, frame_sel_n};
			sync2_r <= sync1_r;
			sync3_r <= sync2_r;
		end
	end

	logic fs_fall;
	logic fs_rise;
	logic sclk_fall;
	logic data_s;
	logic clr_fall;
	logic load_outputs_strobe_fall;

	assign fs_fall   = sync3_r[0] && !sync2_r[0];
	assign fs_rise   = !sync3_r[0] && sync2_r[0];
	assign sclk_fall = sync3_r[1] && !sync2_r[1];
	assign data_s    = sync2_r[2];
	assign clr_fall  = sync3_r[3] && !sync2_r[3];
	assign load_outputs_strobe_fall = sync3_r[4] && !sync2_r[4];

	// receive side
	ddcp_pkg::ddcp_rx_state_t rx_state_r;
	ddcp_pkg::ddcp_frame_t    shreg_r;
	logic [4:0]               bit_cnt_r;
	logic                     frame_done;
	logic                     push_ready;

	assign frame_done = rx_state_r == ddcp_pkg::RX_SHIFT && sclk_fall &&
	                    bit_cnt_r == `DDCP_LAST_BIT;

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			rx_state_r <= ddcp_pkg::RX_IDLE;
		end else begin
			unique case (rx_state_r)
				ddcp_pkg::RX_IDLE: begin
					if (fs_fall) begin
						rx_state_r <= ddcp_pkg::RX_SHIFT;
					end
				end
				ddcp_pkg::RX_SHIFT: begin
					if (fs_rise) begin
						rx_state_r <= ddcp_pkg::RX_IDLE;
					end else if (frame_done) begin
						rx_state_r <= ddcp_pkg::RX_PUSH;
					end
				end
				ddcp_pkg::RX_PUSH: begin
					// a full queue holds the frame here; later clocks are ignored
					if (push_ready) begin
						rx_state_r <= ddcp_pkg::RX_LOCK;
					end
				end
				ddcp_pkg::RX_LOCK: begin
					if (sync2_r[0]) begin
						rx_state_r <= ddcp_pkg::RX_IDLE;
					end
				end
			endcase
		end
	end

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			shreg_r   <= '0;
			bit_cnt_r <= 5'h00;
		end else if (rx_state_r == ddcp_pkg::RX_IDLE ||
		             (rx_state_r == ddcp_pkg::RX_SHIFT && fs_rise)) begin
			bit_cnt_r <= 5'h00;
		end else if (rx_state_r == ddcp_pkg::RX_SHIFT && sclk_fall) begin
			shreg_r   <= {shreg_r[`DDCP_FRAME_BITS-2:0], data_s};
			bit_cnt_r <= bit_cnt_r + 5'h01;
		end
	end

	// frame queue between the link and the decoder
	ddcp_pkg::ddcp_frame_t rd_frame;
	logic                  rd_valid;
	logic                  rd_ready;
	logic                  exec;

	// a clear owns its cycle, so the decoder stalls rather than race it
	assign rd_ready = !clr_fall;
	assign exec     = rd_valid && rd_ready;

	ddcp_fifo #(
		.WIDTH (`DDCP_FRAME_BITS),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.clk      (core_clk),
		.rst      (sys_rst),
		.wr_valid (rx_state_r == ddcp_pkg::RX_PUSH),
		.wr_ready (push_ready),
		.wr_data  (shreg_r),
		.rd_valid (rd_valid),
		.rd_ready (rd_ready),
		.rd_data  (rd_frame)
	);

	// decode
	logic [2:0]  cmd;
	logic [2:0]  addr;
	logic [15:0] data;
	logic [15:0] code;
	logic        addr_ok;
	logic        is_write;

	assign cmd      = rd_frame[`DDCP_CMD_HI:`DDCP_CMD_LO];
	assign addr     = rd_frame[`DDCP_ADDR_HI:`DDCP_ADDR_LO];
	assign data     = rd_frame[`DDCP_DATA_HI:0];
	assign code     = data & CODE_MASK;
	assign addr_ok  = addr == `DDCP_ADDR_A || addr == `DDCP_ADDR_B ||
	                  addr == `DDCP_ADDR_BOTH;
	assign is_write = cmd == `DDCP_CMD_WR || cmd == `DDCP_CMD_WR_ALL ||
	                  cmd == `DDCP_CMD_WR_UPD;

	logic        full_reset;
	logic [15:0] in_r  [2];
	logic [15:0] out_r [2];
	logic [1:0]  pd_r  [2];
	logic [1:0]  gain_r;
	logic [1:0]  mask_r;
	logic        ref_r;
	logic        clear_mode_r;

	assign full_reset = exec && cmd == `DDCP_CMD_SWRST && data[0];

	for (genvar ch = 0; ch < 2; ch++) begin : g_chan
		logic        hit;
		logic        upd_own;
		logic [15:0] in_nxt;

		assign hit     = addr == (ch == 0 ? `DDCP_ADDR_A : `DDCP_ADDR_B) ||
		                 addr == `DDCP_ADDR_BOTH;
		assign upd_own = exec && (((cmd == `DDCP_CMD_UPD || cmd == `DDCP_CMD_WR_UPD)
		                 && hit) || (cmd == `DDCP_CMD_WR_ALL && addr_ok));
		assign in_nxt  = (exec && is_write && hit) ? code : in_r[ch];

		always_ff @(posedge core_clk or posedge sys_rst) begin
			if (sys_rst) begin
				in_r[ch]  <= RST_CODE;
				out_r[ch] <= RST_CODE;
			end else if (clr_fall) begin
				in_r[ch]  <= RST_CODE;
				out_r[ch] <= RST_CODE;
			end else if (exec && cmd == `DDCP_CMD_SWRST) begin
				in_r[ch]  <= RST_CODE;
				out_r[ch] <= RST_CODE;
			end else begin
				in_r[ch] <= in_nxt;
				if (upd_own || (load_outputs_strobe_fall && !mask_r[ch])) begin
					out_r[ch] <= in_nxt;
				end
			end
		end

		always_ff @(posedge core_clk or posedge sys_rst) begin
			if (sys_rst) begin
				pd_r[ch] <= `DDCP_PD_RST;
			end else if (exec && cmd == `DDCP_CMD_PWR && data[ch]) begin
				pd_r[ch] <= data[`DDCP_PD_HI:`DDCP_PD_LO];
			end else if (full_reset) begin
				pd_r[ch] <= `DDCP_PD_RST;
			end
		end
	end

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			gain_r <= `DDCP_GAIN_RST;
		end else if (exec && cmd == `DDCP_CMD_WR && addr == `DDCP_ADDR_GAIN) begin
			gain_r <= data[1:0];
		end else if (exec && cmd == `DDCP_CMD_REF) begin
			gain_r <= data[0] ? 2'h0 : `DDCP_GAIN_RST;
		end else if (full_reset) begin
			gain_r <= `DDCP_GAIN_RST;
		end
	end

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			mask_r <= `DDCP_MASK_RST;
			ref_r  <= `DDCP_REF_RST;
		end else if (full_reset) begin
			mask_r <= `DDCP_MASK_RST;
			ref_r  <= `DDCP_REF_RST;
		end else if (exec && cmd == `DDCP_CMD_MASK) begin
			mask_r <= data[1:0];
		end else if (exec && cmd == `DDCP_CMD_REF) begin
			ref_r <= data[0];
		end
	end

	// a new clear edge beats a frame ending in the same cycle
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			clear_mode_r <= 1'b0;
		end else if (clr_fall) begin
			clear_mode_r <= 1'b1;
		end else if (frame_done) begin
			clear_mode_r <= 1'b0;
		end
	end

	assign dac_a_code    = out_r[0];
	assign dac_b_code    = out_r[1];
	assign gain_one      = gain_r;
	assign pd_mode_a     = pd_r[0];
	assign pd_mode_b     = pd_r[1];
	assign load_inactive = mask_r;
	assign ref_enable    = ref_r;
	assign clear_mode    = clear_mode_r;

	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (sys_rst);

	clear_forces_a: assert property (clr_fall |=> clear_mode_r &&
		out_r[0] == RST_CODE && in_r[1] == RST_CODE)
		else $error("clear did not force reset codes");

	clear_exit_a: assert property (clear_mode_r && frame_done && !clr_fall
		|=> !clear_mode_r)
		else $error("clear mode not left at frame end");

	clear_in_frame_a: assert property (rx_state_r == ddcp_pkg::RX_SHIFT &&
		clr_fall |=> out_r[1] == RST_CODE && clear_mode_r)
		else $error("clear during frame ignored");

	shift_order_a: assert property (rx_state_r == ddcp_pkg::RX_SHIFT &&
		sclk_fall && !fs_rise |=> shreg_r[0] == $past(data_s) &&
		shreg_r[23:1] == $past(shreg_r[22:0]))
		else $error("shift order wrong");

	lock_a: assert property (rx_state_r == ddcp_pkg::RX_LOCK
		|=> $stable(shreg_r))
		else $error("shift register changed while locked");

	done_push_a: assert property (frame_done |=>
		rx_state_r == ddcp_pkg::RX_PUSH ##1 (rd_valid || rx_state_r == ddcp_pkg::RX_PUSH))
		else $error("finished frame not offered");

	abort_a: assert property (rx_state_r == ddcp_pkg::RX_SHIFT && fs_rise
		|=> rx_state_r == ddcp_pkg::RX_IDLE ##1 bit_cnt_r == 5'h00)
		else $error("select rise did not reset the interface");

	abort_nopush_a: assert property (rx_state_r == ddcp_pkg::RX_SHIFT &&
		fs_rise |=> rx_state_r != ddcp_pkg::RX_PUSH [*2])
		else $error("aborted frame was queued");

	gain_write_a: assert property (exec && cmd == `DDCP_CMD_WR &&
		addr == `DDCP_ADDR_GAIN |=> gain_r == $past(data[1:0]))
		else $error("gain write lost");

	mask_write_a: assert property (exec && cmd == `DDCP_CMD_MASK
		|=> mask_r == $past(data[1:0]))
		else $error("load mask write lost");

	ref_write_a: assert property (exec && cmd == `DDCP_CMD_REF
		|=> ref_r == $past(data[0]) && gain_r == ($past(data[0]) ? 2'h0 : 2'h3))
		else $error("reference command wrong");

	reserved_a: assert property (exec && !cmd[2] && !addr_ok &&
		!(cmd == `DDCP_CMD_WR && addr == `DDCP_ADDR_GAIN) && !clr_fall && !load_outputs_strobe_fall
		|=> $stable(out_r[0]) && $stable(in_r[0]) && $stable(out_r[1]))
		else $error("reserved address changed a register");

	cover_frame_c: cover property (frame_done ##[1:40] exec);
	cover_abort_c: cover property (rx_state_r == ddcp_pkg::RX_SHIFT && fs_rise);
	cover_clear_c: cover property (clear_mode_r && frame_done);
	cover_load_outputs_strobe_c:  cover property (load_outputs_strobe_fall && !mask_r[0]);

endmodule : ddcp_top

`default_nettype wire

/* tb/ddcp_host_model.sv */
/*
 Behavioural host that writes frames over the three-wire link.
 Assumes it is called on a core clock edge; link half period 62.5 ns.
*/
`timescale 1ns/10ps
`default_nettype none

module ddcp_host_model #(
	parameter realtime HALF = 62.5
) (
	output logic frame_sel_n,
	output logic serial_clk,
	output logic serial_data
);
	// link clock idles high and stands still between frames
	initial begin
		frame_sel_n = 1'b1;
		serial_clk  = 1'b1;
		serial_data = 1'b0;
	end

	// nbits of the frame, then extra clocks that the device must ignore
	task automatic send(input logic [23:0] frame, input int nbits, input int extra);
		// a 1 ns lead keeps every link edge off the core clock edges
		#1;
		frame_sel_n = 1'b0;
		#(HALF);
		for (int i = 0; i < nbits + extra; i++) begin
			serial_data = (i < 24) ? frame[23 - i] : ~serial_data;
			#(HALF);
			serial_clk = 1'b0;
			#(HALF);
			serial_clk = 1'b1;
		end
		// no pull on the data line, so a released line must not look stable
		serial_data = ~serial_data;
		#(HALF);
		frame_sel_n = 1'b1;
		#(2 * HALF);
	endtask : send
endmodule : ddcp_host_model

`default_nettype wire

/* tb/test_dual_dac_serial_command_port.sv */
/*
 Self-checking bench: a table of frames, then aborts, over-clocking,
 clear and load pin cases. Checks a zero-scale, 16-bit design and a 12-bit, mid-scale one.
*/
`timescale 1ns/10ps
`default_nettype none

module test_dual_dac_serial_command_port;
	typedef struct packed {
		logic [23:0] frame;
		logic [15:0] a;
		logic [15:0] b;
		logic [1:0]  g;
		logic [1:0]  pa;
		logic [1:0]  pb;
		logic [1:0]  m;
		logic        r;
	} ddcp_row_t;

	logic        core_clk              = 1'b0;
	logic        sys_rst               = 1'b1;
	logic        async_clear_in_n      = 1'b1;
	logic        load_outputs_strobe_n = 1'b1;
	logic        frame_sel_n;
	logic        serial_clk;
	logic        serial_data;
	logic [15:0] dac_a_code;
	logic [15:0] dac_b_code;
	logic [1:0]  gain_one;
	logic [1:0]  pd_mode_a;
	logic [1:0]  pd_mode_b;
	logic [1:0]  load_inactive;
	logic        ref_enable;
	logic        clear_mode;
	logic [15:0] m_a_code;
	logic [15:0] m_b_code;
	int          fail_count = 0;
	int          n_checks   = 0;
	ddcp_row_t   rows[15];

	always #5 core_clk = ~core_clk;

	ddcp_host_model host_u (
		.frame_sel_n (frame_sel_n),
		.serial_clk  (serial_clk),
		.serial_data (serial_data)
	);

	ddcp_top #(
		.RES_BITS   (16),
		.MID_SCALE  (1'b0),
		.FIFO_DEPTH (16)
	) dut_u (
		.core_clk              (core_clk),
		.sys_rst               (sys_rst),
		.frame_sel_n           (frame_sel_n),
		.serial_clk            (serial_clk),
		.serial_data           (serial_data),
		.async_clear_in_n      (async_clear_in_n),
		.load_outputs_strobe_n (load_outputs_strobe_n),
		.dac_a_code            (dac_a_code),
		.dac_b_code            (dac_b_code),
		.gain_one              (gain_one),
		.pd_mode_a             (pd_mode_a),
		.pd_mode_b             (pd_mode_b),
		.load_inactive         (load_inactive),
		.ref_enable            (ref_enable),
		.clear_mode            (clear_mode)
	);

	// 12-bit, mid-scale variant on the same link
	ddcp_top #(
		.RES_BITS   (12),
		.MID_SCALE  (1'b1),
		.FIFO_DEPTH (16)
	) dut12_u (
		.core_clk              (core_clk),
		.sys_rst               (sys_rst),
		.frame_sel_n           (frame_sel_n),
		.serial_clk            (serial_clk),
		.serial_data           (serial_data),
		.async_clear_in_n      (async_clear_in_n),
		.load_outputs_strobe_n (load_outputs_strobe_n),
		.dac_a_code            (m_a_code),
		.dac_b_code            (m_b_code),
		.gain_one              (),
		.pd_mode_a             (),
		.pd_mode_b             (),
		.load_inactive         (),
		.ref_enable            (),
		.clear_mode            ()
	);

	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		n_checks++;
		if (g !== e) begin
			fail_count++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	task automatic check_state(input ddcp_row_t r);
		chk("dac_a_code", r.a, dac_a_code);
		chk("dac_b_code", r.b, dac_b_code);
		chk("gain_one", 16'(r.g), 16'(gain_one));
		chk("pd_mode_a", 16'(r.pa), 16'(pd_mode_a));
		chk("pd_mode_b", 16'(r.pb), 16'(pd_mode_b));
		chk("load_inactive", 16'(r.m), 16'(load_inactive));
		chk("ref_enable", 16'(r.r), 16'(ref_enable));
	endtask : check_state

	task automatic settle();
		repeat (12) @(negedge core_clk);
	endtask : settle

	task automatic pulse(input bit ld);
		if (ld)
			load_outputs_strobe_n = 1'b0;
		else
			async_clear_in_n = 1'b0;
		settle();
		load_outputs_strobe_n = 1'b1;
		async_clear_in_n = 1'b1;
		settle();
	endtask : pulse

	task automatic conclude();
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : conclude

	// the two ignored top bits are sent as ones
	initial begin
		rows[0]  = '{24'hC01234, 16'h0000, 16'h0000, 2'h3, 2'h0, 2'h0, 2'h0, 1'h0};
		rows[1]  = '{24'hC80000, 16'h1234, 16'h0000, 2'h3, 2'h0, 2'h0, 2'h0, 1'h0};
		rows[2]  = '{24'hD9ABCD, 16'h1234, 16'hABCD, 2'h3, 2'h0, 2'h0, 2'h0, 1'h0};
		rows[3]  = '{24'hD7FFFF, 16'hFFFF, 16'hFFFF, 2'h3, 2'h0, 2'h0, 2'h0, 1'h0};
		rows[4]  = '{24'hC20001, 16'hFFFF, 16'hFFFF, 2'h1, 2'h0, 2'h0, 2'h0, 1'h0};
		rows[5]  = '{24'hC35555, 16'hFFFF, 16'hFFFF, 2'h1, 2'h0, 2'h0, 2'h0, 1'h0};
		rows[6]  = '{24'hDA0000, 16'hFFFF, 16'hFFFF, 2'h1, 2'h0, 2'h0, 2'h0, 1'h0};
		rows[7]  = '{24'hE00012, 16'hFFFF, 16'hFFFF, 2'h1, 2'h0, 2'h1, 2'h0, 1'h0};
		rows[8]  = '{24'hE00031, 16'hFFFF, 16'hFFFF, 2'h1, 2'h3, 2'h1, 2'h0, 1'h0};
		rows[9]  = '{24'hE00023, 16'hFFFF, 16'hFFFF, 2'h1, 2'h2, 2'h2, 2'h0, 1'h0};
		rows[10] = '{24'hE00001, 16'hFFFF, 16'hFFFF, 2'h1, 2'h0, 2'h2, 2'h0, 1'h0};
		rows[11] = '{24'hF00002, 16'hFFFF, 16'hFFFF, 2'h1, 2'h0, 2'h2, 2'h2, 1'h0};
		rows[12] = '{24'hF80001, 16'hFFFF, 16'hFFFF, 2'h0, 2'h0, 2'h2, 2'h2, 1'h1};
		rows[13] = '{24'hE80000, 16'h0000, 16'h0000, 2'h0, 2'h0, 2'h2, 2'h2, 1'h1};
		rows[14] = '{24'hE80001, 16'h0000, 16'h0000, 2'h3, 2'h0, 2'h0, 2'h0, 1'h0};
		repeat (16) @(negedge core_clk);
		sys_rst = 1'b0;
		settle();
		check_state(rows[14]);
		chk("clear_mode", 16'h0000, 16'(clear_mode));
		chk("m_a_code", 16'h8000, m_a_code);
		$display("reset test done");
		foreach (rows[i]) begin
			host_u.send(rows[i].frame, 24, 0);
			settle();
			check_state(rows[i]);
		end
		$display("table test done");
		host_u.send(24'hD91111, 20, 0);
		host_u.send(24'hD92222, 23, 0);
		settle();
		check_state(rows[14]);
		fork
			host_u.send(24'hD94321, 24, 6);
			begin
				repeat (330) @(negedge core_clk);
				chk("dac_b_code", 16'h4321, dac_b_code);
			end
		join
		settle();
		chk("dac_b_code", 16'h4321, dac_b_code);
		chk("m_b_code", 16'h4320, m_b_code);
		$display("abort and lock test done");
		fork
			host_u.send(24'hC05555, 24, 0);
			begin
				repeat (100) @(negedge core_clk);
				async_clear_in_n = 1'b0;
				settle();
				chk("dac_b_code", 16'h0000, dac_b_code);
				chk("clear_mode", 16'h0001, 16'(clear_mode));
				async_clear_in_n = 1'b1;
			end
		join
		host_u.send(24'hD97777, 24, 0);
		settle();
		chk("dac_b_code", 16'h7777, dac_b_code);
		chk("clear_mode", 16'h0000, 16'(clear_mode));
		pulse(1'b1);
		chk("dac_a_code", 16'h5555, dac_a_code);
		host_u.send(24'hF00001, 24, 0);
		host_u.send(24'hC70123, 24, 0);
		pulse(1'b1);
		chk("dac_a_code", 16'h5555, dac_a_code);
		chk("dac_b_code", 16'h0123, dac_b_code);
		pulse(1'b0);
		chk("dac_a_code", 16'h0000, dac_a_code);
		chk("dac_b_code", 16'h0000, dac_b_code);
		chk("clear_mode", 16'h0001, 16'(clear_mode));
		chk("m_a_code", 16'h8000, m_a_code);
		$display("clear and load test done");
		conclude();
	end

	// guard against a hang anywhere in the sequence
	initial begin
		repeat (100000) @(posedge core_clk);
		fail_count++;
		$display("Error watchdog expected finish seen timeout");
		conclude();
	end
endmodule : test_dual_dac_serial_command_port

`default_nettype wire
